// ===== hdl/atp_regs.vh
// Functional notes
// - Timer source is the system clock; async select switches it to the oscillator pin.
// - While async select is set, both oscillator pins are detached from the port.
// - Prescaler offers stop, undivided, and divide by 8, 32, 64, 128, 256, 1024.
// - Writing one to the async prescaler reset bit resets the async prescaler.
// - A nonzero compare-output field overrides the pin's port function, except 01 in PWM modes where that code does not toggle; direction stays software's.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on compare match.
// - Fast PWM A: 01 toggles only with high mode bit; 10 clear-match/set-bottom; 11 inverse.
// - Fast PWM B: 01 reserved; 10 clear-match/set-bottom; 11 set-match/clear-bottom.
// - Fast PWM: compare A equal TOP with upper bit set ignores match; action at BOTTOM.
// - Phase PWM A: 01 toggles only with high bit; 10 clear up, set down; 11 inverse.
// - Phase PWM B: 01 reserved; 10 clear up-match, set down-match; 11 opposite.
// - Phase PWM: compare equal TOP with upper bit set ignores match; action at TOP.
// - Two low mode bits plus one high mode bit select one of eight modes.
// - Modes: 0 normal, 1 phase, 2 CTC, 3 fast, 5 phase-A, 7 fast-A; 4,6 reserved.
// - Compare update immediate, at TOP or BOTTOM by mode; overflow at MAX, BOTTOM or TOP.
// - Clock select 0 stop, 1 undivided, 2..7 divide by 8,32,64,128,256,1024.
// - Force strobe acts only in non-PWM modes, no interrupt, no clear, reads zero.
// - Async mode control writes go through holding register, commit after two oscillator edges.
`ifndef ATP_REGS_VH
`define ATP_REGS_VH

`define ATP_ADDR_OUT_MODE   8'hB0
`define ATP_ADDR_CLK_FORCE  8'hB1
`define ATP_RST_OUT_MODE    8'h00
`define ATP_RST_CLK_FORCE   8'h00

// Output mode control register fields
`define ATP_COM_A_HI        7
`define ATP_COM_A_LO        6
`define ATP_COM_B_HI        5
`define ATP_COM_B_LO        4
`define ATP_WGM_HI          1
`define ATP_WGM_LO          0
`define ATP_OUT_MODE_MASK   8'hF3

// Clock and force control register fields
`define ATP_FORCE_A         7
`define ATP_FORCE_B         6
`define ATP_WGM_TOP_BIT     3
`define ATP_CS_HI           2
`define ATP_CS_LO           0
`define ATP_CLK_FORCE_MASK  8'h0F

`define ATP_VAL_MAX         8'hFF
`define ATP_VAL_BOTTOM      8'h00

`define ATP_MODE_NORMAL     3'h0
`define ATP_MODE_PHASE_FF   3'h1
`define ATP_MODE_CTC        3'h2
`define ATP_MODE_FAST_FF    3'h3
`define ATP_MODE_RSVD4      3'h4
`define ATP_MODE_PHASE_A    3'h5
`define ATP_MODE_RSVD6      3'h6
`define ATP_MODE_FAST_A     3'h7

`define ATP_COM_OFF         2'h0
`define ATP_COM_TOGGLE      2'h1
`define ATP_COM_CLEAR       2'h2
`define ATP_COM_SET         2'h3

`define ATP_SYNC_EDGES      2'h2
`define ATP_PRESC_WIDTH     10

`endif

// ===== hdl/atp_prescaler.v
`timescale 1ns/1ps
`include "atp_regs.vh"

module atp_prescaler #(
  parameter W = `ATP_PRESC_WIDTH
) (
  input  wire       i_ref_clk,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  input  wire       i_src_tick,
  input  wire       i_clear,
  input  wire [2:0] i_sel,
  output reg        o_tick
);

  reg [W-1:0] cnt_r;
  reg [W-1:0] mask;

  always @* begin
    case (i_sel)
      3'h2:    mask = 10'h007;
      3'h3:    mask = 10'h01F;
      3'h4:    mask = 10'h03F;
      3'h5:    mask = 10'h07F;
      3'h6:    mask = 10'h0FF;
      3'h7:    mask = 10'h3FF;
      default: mask = 10'h000;
    endcase
  end

  always @* begin
    if (i_clear || i_sel == 3'h0) begin
      o_tick = 1'b0;
    end else if (i_sel == 3'h1) begin
      o_tick = i_src_tick;
    end else begin
      o_tick = i_src_tick && ((cnt_r & mask) == mask);
    end
  end

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= {W{1'b0}};
    end else if (i_clk_en) begin
      if (i_clear) begin
        cnt_r <= {W{1'b0}};
      end else if (i_src_tick) begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ===== hdl/atp_timer_ctrl.v
`timescale 1ns/1ps
`include "atp_regs.vh"

module atp_timer_ctrl (
  input  wire       i_ref_clk,
  input  wire       i_arst_n,
  input  wire       i_clk_en,
  input  wire [7:0] i_io_addr,
  input  wire [7:0] i_io_wdata,
  input  wire       i_io_wr,
  input  wire       i_io_rd,
  input  wire       i_async_clock_select,
  input  wire       i_async_prescaler_reset,
  input  wire       i_osc_in_pin,
  input  wire [7:0] i_counter_value,
  input  wire       i_counting_down,
  input  wire       i_count_step,
  input  wire [7:0] i_compare_value_a,
  input  wire [7:0] i_compare_value_b,
  output reg  [7:0] o_io_rdata,
  output reg        o_osc_pins_detached,
  output reg        o_timer_tick,
  output reg  [2:0] o_waveform_mode,
  output reg  [7:0] o_top_value,
  output reg        o_count_updown,
  output reg        o_clear_on_top,
  output reg        o_compare_load,
  output reg        o_overflow_flag_set,
  output reg        o_match_a,
  output reg        o_match_b,
  output reg        o_compare_output_pin_a,
  output reg        o_compare_output_pin_b,
  output reg        o_pin_override_a,
  output reg        o_pin_override_b,
  output reg        o_out_mode_busy,
  output reg        o_clk_force_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator pin synchroniser and edge detect
  reg       osc_s1_r;
  reg       osc_s2_r;
  reg       osc_s3_r;
  wire      osc_rise;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else if (i_clk_en) begin
      osc_s1_r <= i_osc_in_pin;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign osc_rise = osc_s2_r & ~osc_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers with holding stage for async mode
  reg [7:0] out_mode_r;
  reg [7:0] clk_force_r;
  reg [7:0] out_mode_hold_r;
  reg [7:0] clk_force_hold_r;
  reg       out_mode_pend_r;
  reg       clk_force_pend_r;
  reg [1:0] out_mode_edges_r;
  reg [1:0] clk_force_edges_r;
  reg [1:0] force_pulse_r;
  wire      wr_out_mode;
  wire      wr_clk_force;
  wire      commit_out_mode;
  wire      commit_clk_force;
  wire [2:0] mode_after;

  assign wr_out_mode  = i_io_wr && (i_io_addr == `ATP_ADDR_OUT_MODE);
  assign wr_clk_force = i_io_wr && (i_io_addr == `ATP_ADDR_CLK_FORCE);

  // In sync mode a write lands at once; async waits for two oscillator edges
  assign commit_out_mode  = out_mode_pend_r && osc_rise &&
                            (out_mode_edges_r == (`ATP_SYNC_EDGES - 2'h1));
  assign commit_clk_force = clk_force_pend_r && osc_rise &&
                            (clk_force_edges_r == (`ATP_SYNC_EDGES - 2'h1));

  // Mode held in the control registers now, before this cycle's commits, for the mode decode
  assign mode_after = {clk_force_r[`ATP_WGM_TOP_BIT], out_mode_r[`ATP_WGM_HI:`ATP_WGM_LO]};

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_mode_r        <= `ATP_RST_OUT_MODE;
      clk_force_r       <= `ATP_RST_CLK_FORCE;
      out_mode_hold_r   <= `ATP_RST_OUT_MODE;
      clk_force_hold_r  <= `ATP_RST_CLK_FORCE;
      out_mode_pend_r   <= 1'b0;
      clk_force_pend_r  <= 1'b0;
      out_mode_edges_r  <= 2'h0;
      clk_force_edges_r <= 2'h0;
      force_pulse_r     <= 2'h0;
    end else if (i_clk_en) begin
      force_pulse_r <= 2'h0;
      // Output mode control register
      if (wr_out_mode && !i_async_clock_select) begin
        out_mode_r      <= i_io_wdata & `ATP_OUT_MODE_MASK;
        out_mode_pend_r <= 1'b0;
      end else if (wr_out_mode) begin
        out_mode_hold_r  <= i_io_wdata & `ATP_OUT_MODE_MASK;
        out_mode_pend_r  <= 1'b1;
        out_mode_edges_r <= 2'h0;
      end else if (commit_out_mode) begin
        out_mode_r      <= out_mode_hold_r;
        out_mode_pend_r <= 1'b0;
      end else if (out_mode_pend_r && osc_rise) begin
        out_mode_edges_r <= out_mode_edges_r + 2'h1;
      end
      // Clock and force control register; force bits stored only in the async holding register
      if (wr_clk_force && !i_async_clock_select) begin
        clk_force_r      <= i_io_wdata & `ATP_CLK_FORCE_MASK;
        clk_force_pend_r <= 1'b0;
        if (!mode_is_pwm({i_io_wdata[`ATP_WGM_TOP_BIT], out_mode_r[`ATP_WGM_HI:`ATP_WGM_LO]})) begin
          force_pulse_r <= {i_io_wdata[`ATP_FORCE_A], i_io_wdata[`ATP_FORCE_B]};
        end
      end else if (wr_clk_force) begin
        clk_force_hold_r  <= i_io_wdata;
        clk_force_pend_r  <= 1'b1;
        clk_force_edges_r <= 2'h0;
      end else if (commit_clk_force) begin
        clk_force_r      <= clk_force_hold_r & `ATP_CLK_FORCE_MASK;
        clk_force_pend_r <= 1'b0;
        if (!mode_is_pwm({clk_force_hold_r[`ATP_WGM_TOP_BIT], out_mode_r[`ATP_WGM_HI:`ATP_WGM_LO]})) begin
          force_pulse_r <= {clk_force_hold_r[`ATP_FORCE_A], clk_force_hold_r[`ATP_FORCE_B]};
        end
      end else if (clk_force_pend_r && osc_rise) begin
        clk_force_edges_r <= clk_force_edges_r + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  function mode_is_pwm;
    input [2:0] m;
    begin
      mode_is_pwm = (m == `ATP_MODE_PHASE_FF) || (m == `ATP_MODE_PHASE_A) ||
                    (m == `ATP_MODE_FAST_FF) || (m == `ATP_MODE_FAST_A);
    end
  endfunction

  wire       is_nonpwm;
  wire       is_fast;
  wire       is_phase;
  wire       top_from_a;
  wire [7:0] top_val;
  wire       at_bottom;
  wire       at_top;
  wire       at_max;

  assign is_nonpwm  = (mode_after == `ATP_MODE_NORMAL) || (mode_after == `ATP_MODE_CTC);
  assign is_fast    = (mode_after == `ATP_MODE_FAST_FF) || (mode_after == `ATP_MODE_FAST_A);
  assign is_phase   = (mode_after == `ATP_MODE_PHASE_FF) || (mode_after == `ATP_MODE_PHASE_A);
  assign top_from_a = (mode_after == `ATP_MODE_CTC) || (mode_after == `ATP_MODE_PHASE_A) ||
                      (mode_after == `ATP_MODE_FAST_A);
  assign top_val    = top_from_a ? i_compare_value_a : `ATP_VAL_MAX;
  assign at_bottom  = i_count_step && (i_counter_value == `ATP_VAL_BOTTOM);
  assign at_top     = i_count_step && (i_counter_value == top_val);
  assign at_max     = i_count_step && (i_counter_value == `ATP_VAL_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Clock source and prescaler
  wire src_tick;
  wire presc_tick;

  // Source clock is the system clock unless the oscillator pin is selected
  assign src_tick = i_async_clock_select ? osc_rise : 1'b1;

  atp_prescaler #(
    .W (`ATP_PRESC_WIDTH)
  ) u_presc (
    .i_ref_clk  (i_ref_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_src_tick (src_tick),
    .i_clear    (i_async_prescaler_reset),
    .i_sel      (clk_force_r[`ATP_CS_HI:`ATP_CS_LO]),
    .o_tick     (presc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare output waveform, one slice per channel (0 = A, 1 = B)
  wire [1:0] pin_q;
  wire [1:0] ovr_nxt;
  wire [1:0] match_ev;
  wire [15:0] cmp_pair;
  wire [3:0]  com_pair;

  assign cmp_pair = {i_compare_value_b, i_compare_value_a};
  assign com_pair = {out_mode_r[`ATP_COM_B_HI:`ATP_COM_B_LO], out_mode_r[`ATP_COM_A_HI:`ATP_COM_A_LO]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire [7:0] cmp;
      wire [1:0] com;
      wire       code1_live;
      wire       top_special;
      wire       hit;
      wire       frc;
      reg        pin_r;
      reg        pin_nxt;

      assign cmp = cmp_pair[8*ch +: 8];
      assign com = com_pair[2*ch +: 2];
      // Code 01 in PWM toggles only on channel A with the high mode bit set
      assign code1_live  = (ch == 0) && clk_force_r[`ATP_WGM_TOP_BIT];
      assign top_special = (cmp == top_val) && com[1] && ((ch == 0) || is_phase);
      assign hit         = i_count_step && (i_counter_value == cmp);
      assign frc         = (ch == 0) ? force_pulse_r[1] : force_pulse_r[0];
      assign match_ev[ch] = hit;
      assign ovr_nxt[ch]  = (com != `ATP_COM_OFF) &&
                            !(!is_nonpwm && (com == `ATP_COM_TOGGLE) && !code1_live);
      assign pin_q[ch]    = pin_r;

      always @* begin
        pin_nxt = pin_r;
        if (is_nonpwm) begin
          if (hit || frc) begin
            case (com)
              `ATP_COM_TOGGLE: pin_nxt = ~pin_r;
              `ATP_COM_CLEAR:  pin_nxt = 1'b0;
              `ATP_COM_SET:    pin_nxt = 1'b1;
              default:         pin_nxt = pin_r;
            endcase
          end
        end else if (is_fast) begin
          case (com)
            `ATP_COM_TOGGLE: begin
              if (hit && code1_live) pin_nxt = ~pin_r;
            end
            `ATP_COM_CLEAR: begin
              if (hit && !top_special) pin_nxt = 1'b0;
              else if (at_bottom) pin_nxt = 1'b1;
            end
            `ATP_COM_SET: begin
              if (hit && !top_special) pin_nxt = 1'b1;
              else if (at_bottom) pin_nxt = 1'b0;
            end
            default: pin_nxt = pin_r;
          endcase
        end else if (is_phase) begin
          case (com)
            `ATP_COM_TOGGLE: begin
              if (hit && code1_live) pin_nxt = ~pin_r;
            end
            `ATP_COM_CLEAR: begin
              if (top_special) begin
                if (at_top) pin_nxt = 1'b1;
              end else if (hit) begin
                pin_nxt = i_counting_down;
              end
            end
            `ATP_COM_SET: begin
              if (top_special) begin
                if (at_top) pin_nxt = 1'b0;
              end else if (hit) begin
                pin_nxt = ~i_counting_down;
              end
            end
            default: pin_nxt = pin_r;
          endcase
        end
      end

      always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          pin_r <= 1'b0;
        end else if (i_clk_en) begin
          pin_r <= pin_nxt;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Update and overflow event decode
  reg  load_nxt;
  reg  ovf_nxt;

  always @* begin
    load_nxt = 1'b0;
    ovf_nxt  = 1'b0;
    if (is_phase) begin
      load_nxt = at_top;
      ovf_nxt  = at_bottom;
    end else if (is_fast) begin
      load_nxt = at_bottom;
      ovf_nxt  = (mode_after == `ATP_MODE_FAST_A) ? at_top : at_max;
    end else begin
      // Reserved codes behave as normal counting, no waveform
      load_nxt = 1'b1;
      ovf_nxt  = at_max;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_io_rdata             <= 8'h00;
      o_osc_pins_detached    <= 1'b0;
      o_timer_tick           <= 1'b0;
      o_waveform_mode        <= 3'h0;
      o_top_value            <= `ATP_VAL_MAX;
      o_count_updown         <= 1'b0;
      o_clear_on_top         <= 1'b0;
      o_compare_load         <= 1'b1;
      o_overflow_flag_set    <= 1'b0;
      o_match_a              <= 1'b0;
      o_match_b              <= 1'b0;
      o_compare_output_pin_a <= 1'b0;
      o_compare_output_pin_b <= 1'b0;
      o_pin_override_a       <= 1'b0;
      o_pin_override_b       <= 1'b0;
      o_out_mode_busy        <= 1'b0;
      o_clk_force_busy       <= 1'b0;
    end else if (i_clk_en) begin
      if (i_io_rd && i_io_addr == `ATP_ADDR_OUT_MODE) begin
        o_io_rdata <= out_mode_r;
      end else if (i_io_rd && i_io_addr == `ATP_ADDR_CLK_FORCE) begin
        o_io_rdata <= clk_force_r;
      end else begin
        o_io_rdata <= 8'h00;
      end
      o_osc_pins_detached    <= i_async_clock_select;
      o_timer_tick           <= presc_tick;
      o_waveform_mode        <= mode_after;
      o_top_value            <= top_val;
      o_count_updown         <= is_phase;
      o_clear_on_top         <= top_from_a && !is_phase;
      o_compare_load         <= load_nxt;
      o_overflow_flag_set    <= ovf_nxt;
      // Forced compares never reach the match outputs, so no interrupt
      o_match_a              <= match_ev[0];
      o_match_b              <= match_ev[1];
      o_compare_output_pin_a <= pin_q[0];
      o_compare_output_pin_b <= pin_q[1];
      o_pin_override_a       <= ovr_nxt[0];
      o_pin_override_b       <= ovr_nxt[1];
      o_out_mode_busy        <= out_mode_pend_r;
      o_clk_force_busy       <= clk_force_pend_r;
    end
  end

endmodule

// ===== bench/atp_timer_ctrl_assertions.sv
`timescale 1ns/1ps
`include "atp_regs.vh"
module atp_timer_ctrl_chk (
  input wire       i_ref_clk,
  input wire       i_arst_n,
  input wire       i_clk_en,
  input wire [7:0] i_io_addr,
  input wire       i_io_rd,
  input wire       i_async_clock_select,
  input wire       i_count_step,
  input wire [7:0] o_io_rdata,
  input wire       o_osc_pins_detached,
  input wire [2:0] o_waveform_mode,
  input wire [7:0] o_top_value,
  input wire       o_count_updown,
  input wire       o_clear_on_top,
  input wire       o_overflow_flag_set,
  input wire       o_match_a,
  input wire       o_match_b,
  input wire       o_out_mode_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////
  sequence s_rd_out; i_clk_en && i_io_rd && i_io_addr == `ATP_ADDR_OUT_MODE; endsequence
  sequence s_rd_clk; i_clk_en && i_io_rd && i_io_addr == `ATP_ADDR_CLK_FORCE; endsequence
  sequence s_rd_none;
    i_clk_en && i_io_rd && i_io_addr != `ATP_ADDR_OUT_MODE && i_io_addr != `ATP_ADDR_CLK_FORCE;
  endsequence
  sequence s_mode_held; o_waveform_mode == $past(o_waveform_mode); endsequence
  ////////////////////////////////////////////////////////////////
  a_out_rsvd_zero: assert property (s_rd_out |=> o_io_rdata[3:2] == 2'h0)
    else $error("reserved output mode bits read nonzero");
  a_force_reads_zero: assert property (s_rd_clk |=> o_io_rdata[7:4] == 4'h0)
    else $error("force or reserved bits read nonzero");
  a_unmapped_zero: assert property (s_rd_none |=> o_io_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_rdata_idle: assert property (i_clk_en && !i_io_rd |=> o_io_rdata == 8'h00)
    else $error("read data without a read");
  a_detach_follow: assert property (i_clk_en |=> o_osc_pins_detached == $past(i_async_clock_select))
    else $error("oscillator pin detach does not follow select");
  a_fixed_top: assert property (s_mode_held ##0 (o_waveform_mode != 3'h2 && o_waveform_mode != 3'h5 &&
    o_waveform_mode != 3'h7) |-> o_top_value == 8'hFF)
    else $error("fixed top mode without top 0xFF");
  a_updown_decode: assert property (s_mode_held |->
    o_count_updown == (o_waveform_mode == 3'h1 || o_waveform_mode == 3'h5))
    else $error("up-down counting wrong for mode");
  a_clear_top: assert property (s_mode_held |->
    o_clear_on_top == (o_waveform_mode == 3'h2 || o_waveform_mode == 3'h7))
    else $error("clear on top wrong for mode");
  a_match_cause: assert property (o_match_a || o_match_b |-> $past(i_count_step) || $past(i_count_step, 2))
    else $error("match pulse without count step");
  a_ovf_cause: assert property (o_overflow_flag_set |-> $past(i_count_step) || $past(i_count_step, 2))
    else $error("overflow pulse without count step");
  a_sync_nobusy: assert property (!o_osc_pins_detached && !$past(o_osc_pins_detached) |-> !o_out_mode_busy)
    else $error("busy in synchronous mode");
endmodule

bind atp_timer_ctrl atp_timer_ctrl_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_io_addr(i_io_addr),
  .i_io_rd(i_io_rd), .i_async_clock_select(i_async_clock_select), .i_count_step(i_count_step),
  .o_io_rdata(o_io_rdata), .o_osc_pins_detached(o_osc_pins_detached), .o_waveform_mode(o_waveform_mode),
  .o_top_value(o_top_value), .o_count_updown(o_count_updown), .o_clear_on_top(o_clear_on_top),
  .o_overflow_flag_set(o_overflow_flag_set), .o_match_a(o_match_a), .o_match_b(o_match_b),
  .o_out_mode_busy(o_out_mode_busy)
);

// ===== bench/test_atp_timer_ctrl.sv
`timescale 1ns/1ps
`include "atp_regs.vh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module test_atp_timer_ctrl;
  localparam int DIVS [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic       i_ref_clk, i_arst_n, i_clk_en, i_io_wr, i_io_rd, i_async_clock_select, osc_run;
  logic       i_async_prescaler_reset, i_osc_in_pin, i_counting_down, i_count_step;
  logic [7:0] i_io_addr, i_io_wdata, i_counter_value, i_compare_value_a, i_compare_value_b;
  wire  [7:0] o_io_rdata, o_top_value;
  wire  [2:0] o_waveform_mode;
  wire        o_osc_pins_detached, o_timer_tick, o_count_updown, o_clear_on_top, o_compare_load;
  wire        o_overflow_flag_set, o_match_a, o_match_b, pin_a, pin_b, ovr_a, ovr_b, busy_a, busy_b;
  int         mismatches, check_count, n_ma, n_ovf, n_tick, osc_cnt, n, t;
  atp_timer_ctrl DUT (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_osc_in_pin(i_osc_in_pin),
    .i_async_clock_select(i_async_clock_select), .i_async_prescaler_reset(i_async_prescaler_reset),
    .i_counter_value(i_counter_value), .i_counting_down(i_counting_down), .i_count_step(i_count_step),
    .i_compare_value_a(i_compare_value_a), .i_compare_value_b(i_compare_value_b), .o_io_rdata(o_io_rdata),
    .o_osc_pins_detached(o_osc_pins_detached), .o_timer_tick(o_timer_tick), .o_waveform_mode(o_waveform_mode),
    .o_top_value(o_top_value), .o_count_updown(o_count_updown), .o_clear_on_top(o_clear_on_top),
    .o_compare_load(o_compare_load), .o_overflow_flag_set(o_overflow_flag_set), .o_match_a(o_match_a),
    .o_match_b(o_match_b), .o_compare_output_pin_a(pin_a), .o_compare_output_pin_b(pin_b),
    .o_pin_override_a(ovr_a), .o_pin_override_b(ovr_b), .o_out_mode_busy(busy_a), .o_clk_force_busy(busy_b)
  );
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // Oscillator only runs while the async scenario wants it
  always @(posedge i_ref_clk) begin
    if (osc_run) begin
      osc_cnt <= (osc_cnt == 3) ? 0 : osc_cnt + 1;
      if (osc_cnt == 3) i_osc_in_pin <= ~i_osc_in_pin;
    end
    n_ma <= n_ma + (o_match_a | o_match_b);
    n_ovf <= n_ovf + o_overflow_flag_set;
    n_tick <= n_tick + o_timer_tick;
  end
  ////////////////////////////////////////////////////////////////
  task end_sim;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_ref_clk);
    i_io_addr <= a; i_io_wdata <= d; i_io_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_io_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge i_ref_clk);
    i_io_addr <= a; i_io_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_io_rd <= 1'b0;
    @(negedge i_ref_clk);
    `CHK("rdata", e, o_io_rdata)
  endtask
  task mode(input [7:0] a, input [7:0] b);
    wr(`ATP_ADDR_OUT_MODE, a);
    wr(`ATP_ADDR_CLK_FORCE, b);
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task step(input [7:0] c, input d);
    @(posedge i_ref_clk);
    i_counter_value <= c; i_counting_down <= d; i_count_step <= 1'b1;
    @(posedge i_ref_clk);
    i_count_step <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task wait_tick(output int c);
    c = 0;
    do begin @(negedge i_ref_clk); c++; end while (o_timer_tick !== 1'b1 && c < 2100);
    if (c >= 2100) begin mismatches++; end_sim; end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    @(negedge i_ref_clk);
    `CHK("top", 8'hFF, o_top_value)
    `CHK("detach", 1'b0, o_osc_pins_detached)
    rd(`ATP_ADDR_OUT_MODE, `ATP_RST_OUT_MODE);
    rd(`ATP_ADDR_CLK_FORCE, `ATP_RST_CLK_FORCE);
    wr(`ATP_ADDR_OUT_MODE, 8'hFF);
    rd(`ATP_ADDR_OUT_MODE, 8'hF3);
    wr(`ATP_ADDR_CLK_FORCE, 8'hFF);
    rd(`ATP_ADDR_CLK_FORCE, 8'h0F);
    rd(8'hB2, 8'h00);
  endtask
  task t_modes;
    i_compare_value_a <= 8'h40;
    for (int m = 0; m < 8; m++) begin
      mode({6'h00, m[1:0]}, {4'h0, m[2], 3'h0});
      `CHK("mode", m[2:0], o_waveform_mode)
      `CHK("top", (m == 2 || m == 5 || m == 7) ? 8'h40 : 8'hFF, o_top_value)
      `CHK("updown", (m == 1 || m == 5), o_count_updown)
      `CHK("clrtop", (m == 2 || m == 7), o_clear_on_top)
    end
  endtask
  task t_presc;
    for (int s = 1; s < 8; s++) begin
      wr(`ATP_ADDR_CLK_FORCE, s[7:0]);
      @(posedge i_ref_clk) i_async_prescaler_reset <= 1'b1;
      @(posedge i_ref_clk) i_async_prescaler_reset <= 1'b0;
      wait_tick(t);
      `CHK("first", 1'b1, (t >= DIVS[s] && t <= DIVS[s] + 3))
      wait_tick(t);
      `CHK("period", DIVS[s], t)
    end
    wr(`ATP_ADDR_CLK_FORCE, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    n = n_tick;
    repeat (50) @(posedge i_ref_clk);
    `CHK("stopped", n, n_tick)
  endtask
  task t_force;
    mode(8'h70, 8'h00);
    `CHK("ovr", 2'b11, {ovr_a, ovr_b})
    n = n_ma;
    for (int k = 0; k < 2; k++) begin
      wr(`ATP_ADDR_CLK_FORCE, 8'hC0);
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `CHK("force", {~k[0], 1'b1}, {pin_a, pin_b})
    end
    `CHK("nomatch", n, n_ma)
    rd(`ATP_ADDR_CLK_FORCE, 8'h00);
    mode(8'hA0, 8'hC0);
    `CHK("fclr", 2'b00, {pin_a, pin_b})
    mode(8'hF3, 8'h00);
    wr(`ATP_ADDR_CLK_FORCE, 8'hC0);
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("fpwm", 2'b00, {pin_a, pin_b})
  endtask
  task t_normal;
    i_compare_value_a <= 8'h10; i_compare_value_b <= 8'h20;
    mode(8'h40, 8'h00);
    `CHK("ld", 1'b1, o_compare_load)
    n = n_ma; t = n_ovf;
    step(8'h10, 1'b0);
    `CHK("tog", 1'b1, pin_a)
    `CHK("match", n + 1, n_ma)
    step(8'h11, 1'b0);
    `CHK("hold", 1'b1, pin_a)
    step(8'hFF, 1'b0);
    `CHK("ovf", t + 1, n_ovf)
  endtask
  task t_fast;
    i_compare_value_a <= 8'h20; i_compare_value_b <= 8'h30;
    mode(8'hA3, 8'h00);
    `CHK("ld", 1'b0, o_compare_load)
    step(8'h20, 1'b0);
    `CHK("fa", 1'b0, pin_a)
    step(8'h00, 1'b0);
    `CHK("fbot", 2'b11, {pin_a, pin_b})
    step(8'h30, 1'b0);
    `CHK("fb", 1'b0, pin_b)
    mode(8'hF3, 8'h00);
    step(8'h00, 1'b0);
    `CHK("ibot", 2'b00, {pin_a, pin_b})
    step(8'h20, 1'b0);
    `CHK("ia", 1'b1, pin_a)
    i_compare_value_a <= 8'hFF;
    mode(8'h83, 8'h00);
    step(8'h00, 1'b0);
    step(8'hFF, 1'b0);
    `CHK("ftop", 1'b1, pin_a)
    mode(8'h53, 8'h00);
    `CHK("rsv", 2'b00, {ovr_a, ovr_b})
    mode(8'h53, 8'h08);
    `CHK("tog7", 1'b1, ovr_a)
  endtask
  task t_phase;
    i_compare_value_a <= 8'h20; i_compare_value_b <= 8'h30;
    mode(8'hA1, 8'h00);
    step(8'h20, 1'b0);
    `CHK("pup", 1'b0, pin_a)
    step(8'h20, 1'b1);
    `CHK("pdn", 1'b1, pin_a)
    step(8'h30, 1'b0);
    `CHK("pbup", 1'b0, pin_b)
    step(8'h30, 1'b1);
    `CHK("pbdn", 1'b1, pin_b)
    step(8'h20, 1'b0);
    i_compare_value_a <= 8'hFF;
    t = n_ovf;
    step(8'hFF, 1'b0);
    `CHK("ptop", 1'b1, pin_a)
    `CHK("novf", t, n_ovf)
    step(8'h00, 1'b1);
    `CHK("povf", t + 1, n_ovf)
  endtask
  task t_async;
    i_async_clock_select <= 1'b1; osc_run <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("detach", 1'b1, o_osc_pins_detached)
    wr(`ATP_ADDR_CLK_FORCE, 8'h01);
    @(posedge i_ref_clk);
    t = 0;
    do begin @(negedge i_ref_clk); t++; end while (busy_b !== 1'b0 && t < 300);
    if (t >= 300) begin mismatches++; end_sim; end
    `CHK("commit", 1'b1, (t >= 8))
    rd(`ATP_ADDR_CLK_FORCE, 8'h01);
    n = n_tick;
    repeat (80) @(posedge i_ref_clk);
    `CHK("osctick", 1'b1, (n_tick - n >= 9 && n_tick - n <= 11))
    osc_run <= 1'b0; i_async_clock_select <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {i_arst_n, i_io_wr, i_io_rd, i_async_clock_select, osc_run, i_osc_in_pin} = 6'h00;
    {i_async_prescaler_reset, i_counting_down, i_count_step} = 3'h0;
    {i_io_addr, i_io_wdata, i_counter_value, i_compare_value_a, i_compare_value_b} = 40'h0;
    {mismatches, check_count, n_ma, n_ovf, n_tick, osc_cnt} = '0;
    i_clk_en = 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    t_reset;
    t_modes;
    t_presc;
    t_force;
    t_normal;
    t_fast;
    t_phase;
    t_async;
    end_sim;
  end
endmodule
